// file: hw/t2c_regs.svh
// Register indices, field positions, reset values and timing counts of the timer.
// Assumes byte addresses on the bus are four times the register index.
`ifndef T2C_REGS_SVH
`define T2C_REGS_SVH
// Register indices
`define T2C_IDX_PIN_FUNC 8'ha6
`define T2C_IDX_CTRL 8'hc8
`define T2C_IDX_RCAP_LO 8'hca
`define T2C_IDX_RCAP_HI 8'hcb
`define T2C_IDX_CNT_LO 8'hcc
`define T2C_IDX_CNT_HI 8'hcd
`define T2C_IDX_AUXILIARY_CONTROL_ONE 8'hf8
// Control register fields
`define T2C_BIT_OVF 7
`define T2C_BIT_EXT 6
`define T2C_BIT_RX_SEL 5
`define T2C_BIT_TX_SEL 4
`define T2C_BIT_EXEN 3
`define T2C_BIT_RUN 2
`define T2C_BIT_CT 1
`define T2C_BIT_CPRL 0
// Pin function and auxiliary fields
`define T2C_BIT_OUT_EN 1
`define T2C_PIN_FUNC_MASK 8'hf7
`define T2C_BIT_SRC_SEL 2
// Reset values
`define T2C_RST_BYTE 8'h00
`define T2C_RST_WORD 16'h0000
// Timing counts
`define T2C_TIMER_DIV 2
`define T2C_SLOW_DIV 16
`endif

// file: hw/t2c_pkg.sv
// Types shared by the timer design.
// Assumes the register header is included by users of the constants.
package t2c_pkg;
	typedef logic [7:0] t2c_byte_t;
	typedef logic [15:0] t2c_word_t;
	// Source of count increments
	typedef enum logic [1:0] {T2C_SRC_TIMER, T2C_SRC_PIN, T2C_SRC_SLOW} t2c_src_e;
endpackage

// file: hw/t2c_timer.sv
// Sixteen-bit capture/reload timer with a classic Wishbone register slave.
// Assumes one clock; count, trigger and slow clock pins are asynchronous.
//
// What this block does
// - The rx and tx baud select bits pick this timer's overflow over the other timer's.
// - In timer mode the running count steps once every two clock cycles.
// - In counter mode the running count steps on each count pin falling edge or each 16th slow clock rising edge.
// - The source select bit picks the count pin at 0 and the slow clock over 16 at 1.
// - With output enable set the toggle output flips on each overflow, else it stays low.
// - Two byte registers hold the reload value and receive the captured count.
// - The live count reads and writes as two bytes, a write replacing that byte.
// - Overflow sets the overflow flag unless a baud select bit is set; software clears it.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "t2c_regs.svh"
module t2c_timer
	import t2c_pkg::*;
#(
	parameter int SLOW_DIV = `T2C_SLOW_DIV
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins
	input wire logic count_pin_i,
	input wire logic trigger_pin_i,
	input wire logic slow_clock_i,
	output logic overflow_toggle_out_o,
	output logic overflow_output_enable_o,
	// Serial port baud ticks
	input wire logic timer1_overflow_i,
	output logic rx_baud_tick_o,
	output logic tx_baud_tick_o
);
	localparam int PW = $clog2(`T2C_TIMER_DIV);
	localparam int SW = $clog2(SLOW_DIV);
	localparam logic [PW-1:0] PRESC_LAST = PW'(`T2C_TIMER_DIV - 1);
	localparam logic [SW-1:0] SLOW_LAST = SW'(SLOW_DIV - 1);

	// Divider must be a power of two of at least two
	if (SLOW_DIV < 2 || (1 << SW) != SLOW_DIV) begin : g_bad_div
		$error("SLOW_DIV must be a power of two of at least 2");
	end

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [2:0] pin_raw;
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic [2:0] sync3_r;
	assign pin_raw = {slow_clock_i, trigger_pin_i, count_pin_i};
	// Third stage keeps the previous level for edge detection
	for (genvar g = 0; g < 3; g++) begin : g_sync
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				sync1_r[g] <= 1'b1;
				sync2_r[g] <= 1'b1;
				sync3_r[g] <= 1'b1;
			end else begin
				sync1_r[g] <= pin_raw[g];
				sync2_r[g] <= sync1_r[g];
				sync3_r[g] <= sync2_r[g];
			end
		end
	end
	logic count_fall;
	logic trig_fall;
	logic slow_rise;
	assign count_fall = sync3_r[0] & ~sync2_r[0];
	assign trig_fall = sync3_r[1] & ~sync2_r[1];
	assign slow_rise = ~sync3_r[2] & sync2_r[2];

	// ************************************************************
	// Register state
	// ************************************************************
	t2c_byte_t ctrl_r, ctrl_nxt;
	t2c_byte_t pin_func_r, pin_func_nxt;
	t2c_byte_t auxiliary_control_one_r, auxiliary_control_one_nxt;
	t2c_word_t rcap_r, rcap_nxt;
	t2c_word_t cnt_r, cnt_nxt;
	logic [PW-1:0] presc_r, presc_nxt;
	logic [SW-1:0] slow_div_r, slow_div_nxt;
	logic toggle_r, toggle_nxt;
	logic out_en_r, out_en_nxt;
	logic rx_tick_r, rx_tick_nxt;
	logic tx_tick_r, tx_tick_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;

	// Decoded control fields
	logic run, ct_mode, exen, cprl, rx_sel, tx_sel, forced, reload_mode;
	assign run = ctrl_r[`T2C_BIT_RUN];
	assign ct_mode = ctrl_r[`T2C_BIT_CT];
	assign exen = ctrl_r[`T2C_BIT_EXEN];
	assign cprl = ctrl_r[`T2C_BIT_CPRL];
	assign rx_sel = ctrl_r[`T2C_BIT_RX_SEL];
	assign tx_sel = ctrl_r[`T2C_BIT_TX_SEL];
	assign forced = rx_sel | tx_sel;
	assign reload_mode = ~cprl | forced;

	// Bus access decode; one wait state gives a registered answer
	logic access, wr;
	logic [7:0] idx;
	assign access = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr = access & wb_we_i & wb_sel_i[0];
	assign idx = wb_adr_i[9:2];
	logic wr_ctrl, wr_cnt_lo, wr_cnt_hi, wr_rcap_lo, wr_rcap_hi;
	assign wr_ctrl = wr && idx == `T2C_IDX_CTRL;
	assign wr_cnt_lo = wr && idx == `T2C_IDX_CNT_LO;
	assign wr_cnt_hi = wr && idx == `T2C_IDX_CNT_HI;
	assign wr_rcap_lo = wr && idx == `T2C_IDX_RCAP_LO;
	assign wr_rcap_hi = wr && idx == `T2C_IDX_RCAP_HI;

	// ************************************************************
	// Count events
	// ************************************************************
	t2c_src_e src;
	logic tick_t, slow_tick, inc, ovf, trig;
	always_comb begin
		if (!ct_mode) begin
			src = T2C_SRC_TIMER;
		end else if (auxiliary_control_one_r[`T2C_BIT_SRC_SEL]) begin
			src = T2C_SRC_SLOW;
		end else begin
			src = T2C_SRC_PIN;
		end
	end
	assign tick_t = presc_r == PRESC_LAST;
	assign slow_tick = slow_rise && slow_div_r == SLOW_LAST;
	// Step only while running; the event select follows the mode
	always_comb begin
		inc = 1'b0; // Safe value for the one source code never produced
		unique case (src)
			T2C_SRC_TIMER: inc = run & tick_t;
			T2C_SRC_PIN: inc = run & count_fall;
			T2C_SRC_SLOW: inc = run & slow_tick;
		endcase
	end
	assign ovf = inc && cnt_r == 16'hffff;
	assign trig = exen & trig_fall;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		ctrl_nxt = ctrl_r;
		pin_func_nxt = pin_func_r;
		auxiliary_control_one_nxt = auxiliary_control_one_r;
		rcap_nxt = rcap_r;
		cnt_nxt = cnt_r;
		toggle_nxt = toggle_r;
		// Prescaler is held cleared while stopped so a start is aligned
		presc_nxt = (run && !tick_t) ? presc_r + 1'b1 : '0;
		slow_div_nxt = slow_rise ? slow_div_r + 1'b1 : slow_div_r;
		if (inc) begin
			cnt_nxt = cnt_r + 16'h0001;
		end
		if (reload_mode && (ovf || trig)) begin
			cnt_nxt = rcap_r;
		end
		if (!reload_mode && trig) begin
			rcap_nxt = cnt_r;
		end
		// Software byte writes win over the counting hardware
		if (wr_cnt_lo) begin
			cnt_nxt[7:0] = wb_dat_i[7:0];
		end
		if (wr_cnt_hi) begin
			cnt_nxt[15:8] = wb_dat_i[7:0];
		end
		if (wr_rcap_lo) begin
			rcap_nxt[7:0] = wb_dat_i[7:0];
		end
		if (wr_rcap_hi) begin
			rcap_nxt[15:8] = wb_dat_i[7:0];
		end
		if (wr_ctrl) begin
			ctrl_nxt = wb_dat_i[7:0];
		end
		if (wr && idx == `T2C_IDX_PIN_FUNC) begin
			pin_func_nxt = wb_dat_i[7:0] & `T2C_PIN_FUNC_MASK;
		end
		if (wr && idx == `T2C_IDX_AUXILIARY_CONTROL_ONE) begin
			auxiliary_control_one_nxt = wb_dat_i[7:0];
		end
		// Flag sets come last so an event beats a clear in the same cycle
		if (ovf && !forced) begin
			ctrl_nxt[`T2C_BIT_OVF] = 1'b1;
		end
		if (trig) begin
			ctrl_nxt[`T2C_BIT_EXT] = 1'b1;
		end
		// Toggle output idles low while disabled
		if (!pin_func_r[`T2C_BIT_OUT_EN]) begin
			toggle_nxt = 1'b0;
		end else if (ovf) begin
			toggle_nxt = ~toggle_r;
		end
	end

	// Baud ticks and bus answer
	always_comb begin
		out_en_nxt = pin_func_r[`T2C_BIT_OUT_EN];
		rx_tick_nxt = rx_sel ? ovf : timer1_overflow_i;
		tx_tick_nxt = tx_sel ? ovf : timer1_overflow_i;
		ack_nxt = access;
		dat_nxt = dat_r;
		if (access) begin
			dat_nxt = 32'h0000_0000; // Unmapped reads return zero
			unique case (idx)
				`T2C_IDX_PIN_FUNC: dat_nxt[7:0] = pin_func_r;
				`T2C_IDX_CTRL: dat_nxt[7:0] = ctrl_r;
				`T2C_IDX_RCAP_LO: dat_nxt[7:0] = rcap_r[7:0];
				`T2C_IDX_RCAP_HI: dat_nxt[7:0] = rcap_r[15:8];
				`T2C_IDX_CNT_LO: dat_nxt[7:0] = cnt_r[7:0];
				`T2C_IDX_CNT_HI: dat_nxt[7:0] = cnt_r[15:8];
				`T2C_IDX_AUXILIARY_CONTROL_ONE: dat_nxt[7:0] = auxiliary_control_one_r;
				default: dat_nxt[7:0] = 8'h00;
			endcase
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= `T2C_RST_BYTE;
			pin_func_r <= `T2C_RST_BYTE;
			auxiliary_control_one_r <= `T2C_RST_BYTE;
			rcap_r <= `T2C_RST_WORD;
			cnt_r <= `T2C_RST_WORD;
			presc_r <= '0;
			slow_div_r <= '0;
			toggle_r <= 1'b0;
			out_en_r <= 1'b0;
			rx_tick_r <= 1'b0;
			tx_tick_r <= 1'b0;
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ctrl_r <= ctrl_nxt;
			pin_func_r <= pin_func_nxt;
			auxiliary_control_one_r <= auxiliary_control_one_nxt;
			rcap_r <= rcap_nxt;
			cnt_r <= cnt_nxt;
			presc_r <= presc_nxt;
			slow_div_r <= slow_div_nxt;
			toggle_r <= toggle_nxt;
			out_en_r <= out_en_nxt;
			rx_tick_r <= rx_tick_nxt;
			tx_tick_r <= tx_tick_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign overflow_toggle_out_o = toggle_r;
	assign overflow_output_enable_o = out_en_r;
	assign rx_baud_tick_o = rx_tick_r;
	assign tx_baud_tick_o = tx_tick_r;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic cnt_wr;
	assign cnt_wr = wr_cnt_lo | wr_cnt_hi;

	sequence s_timer_step;
		run && !ct_mode && tick_t ##1 run;
	endsequence
	sequence s_gap_then_step;
		!tick_t ##1 tick_t;
	endsequence

	a_ext_flag_set: assert property (trig |=> ctrl_r[`T2C_BIT_EXT])
		else $error("trigger edge did not set external flag");
	a_ext_flag_hold: assert property (ctrl_r[`T2C_BIT_EXT] && !wr_ctrl |=> ctrl_r[`T2C_BIT_EXT])
		else $error("external flag cleared without a write");
	a_baud_select: assert property (##1 rx_baud_tick_o == $past(rx_sel ? ovf : timer1_overflow_i))
		else $error("receive baud tick from wrong source");
	a_timer_rate: assert property (s_timer_step |-> s_gap_then_step)
		else $error("timer mode step not every two cycles");
	a_counter_step: assert property (inc && !ovf && !trig && !cnt_wr |=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("count did not step on its event");
	a_slow_source: assert property (run && ct_mode && auxiliary_control_one_r[`T2C_BIT_SRC_SEL] && !slow_tick |-> !inc)
		else $error("slow source mode stepped without a slow tick");
	a_toggle_out: assert property (ovf && pin_func_r[`T2C_BIT_OUT_EN] |=> toggle_r != $past(toggle_r))
		else $error("toggle output missed an overflow");
	a_capture_value: assert property (trig && !reload_mode && !wr_rcap_lo && !wr_rcap_hi |=> rcap_r == $past(cnt_r))
		else $error("capture did not store the count");
	a_count_write: assert property (wr_cnt_hi |=> cnt_r[15:8] == $past(wb_dat_i[7:0]))
		else $error("count high byte write lost");
	a_ovf_flag: assert property (ovf && !forced |=> ctrl_r[`T2C_BIT_OVF])
		else $error("overflow flag not set");
	a_ovf_forced: assert property (ovf && forced && !wr_ctrl && !ctrl_r[`T2C_BIT_OVF] |=> !ctrl_r[`T2C_BIT_OVF])
		else $error("overflow flag set in baud use");
	a_reload_value: assert property (ovf && reload_mode && !cnt_wr |=> cnt_r == $past(rcap_r))
		else $error("overflow did not reload the count");
	a_stop_hold: assert property (!run && !trig && !cnt_wr |=> cnt_r == $past(cnt_r))
		else $error("stopped count changed");
	a_bus_ack: assert property (access |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a single cycle");
endmodule

// file: test/t2c_pins_model.sv
// Far-side model: count pin, trigger pin, slow clock and the other timer.
// Assumes one bench process calls its task at a time.
`timescale 1ns/100ps
module t2c_pins_model (
	// Clock
	input wire logic clk_i,
	// Lines toward the timer
	output logic count_pin_o,
	output logic trigger_pin_o,
	output logic slow_clock_o,
	output logic timer1_overflow_o
);
	// Pins idle high so that reset release never shows a false edge
	logic [3:0] lv = 4'b0111;
	assign count_pin_o = lv[0];
	assign trigger_pin_o = lv[1];
	assign slow_clock_o = lv[2];
	assign timer1_overflow_o = lv[3];
	// Pulse line sel n times; pins are held four cycles to pass the synchronisers
	task automatic pulse(input int sel, input int n);
		repeat (n) begin
			@(posedge clk_i);
			lv <= lv ^ (4'b0001 << sel);
			repeat ((sel == 3) ? 1 : 4) @(posedge clk_i);
			lv <= lv ^ (4'b0001 << sel);
			repeat ((sel == 3) ? 1 : 4) @(posedge clk_i);
		end
	endtask
endmodule

// file: test/t2c_timer_tb.sv
// Self-checking bench for the capture/reload timer, driven over its register bus.
// Assumes the pin model is the only source of pin activity.
`timescale 1ns/100ps
`include "t2c_regs.svh"
module t2c_timer_tb import t2c_pkg::*; ;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] rdat;
	logic ack, cp, tp, sc, t1, tog, oe, rxt, txt, tog_q;
	int failures = 0;
	int num_checks = 0;
	int tx_n = 0;
	int rx_n = 0;
	int tog_n = 0;
	// *****************************
	// Clock, design and far side
	// *****************************
	always #2 clk_i = ~clk_i;
	t2c_timer #(.SLOW_DIV(2)) i_t2c_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .count_pin_i(cp), .trigger_pin_i(tp),
		.slow_clock_i(sc), .overflow_toggle_out_o(tog), .overflow_output_enable_o(oe),
		.timer1_overflow_i(t1), .rx_baud_tick_o(rxt), .tx_baud_tick_o(txt));
	t2c_pins_model i_t2c_pins_model (.clk_i(clk_i), .count_pin_o(cp), .trigger_pin_o(tp),
		.slow_clock_o(sc), .timer1_overflow_o(t1));
	// Count baud ticks and toggle flips as seen at the ports
	always @(posedge clk_i) begin
		if (txt === 1'b1) tx_n++;
		if (rxt === 1'b1) rx_n++;
		if (tog !== tog_q) tog_n++;
		tog_q = tog;
	end
	task automatic check(input t2c_byte_t seen, input t2c_byte_t exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rng(input int v, input int lo, input int hi);
		check({7'h00, (v >= lo && v <= hi)}, 8'h01);
	endtask
	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Classic cycle: the request stands until ack is sampled high, then drops
	task automatic acc(input logic w, input t2c_byte_t idx, input t2c_byte_t wd,
		output t2c_byte_t rd);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		dat <= {24'h00_0000, wd};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20) begin
			failures++;
			results();
		end
	endtask
	task automatic wr(input t2c_byte_t idx, input t2c_byte_t d);
		t2c_byte_t x;
		acc(1'b1, idx, d, x);
	endtask
	task automatic rc(input t2c_byte_t idx, input t2c_byte_t exp);
		t2c_byte_t x;
		acc(1'b0, idx, 8'h00, x);
		check(x, exp);
	endtask
	// *****************************
	// Scenarios
	// *****************************
	task automatic t_regs();
		t2c_byte_t ix[7] = '{`T2C_IDX_PIN_FUNC, `T2C_IDX_CTRL, `T2C_IDX_RCAP_LO,
			`T2C_IDX_RCAP_HI, `T2C_IDX_CNT_LO, `T2C_IDX_CNT_HI, `T2C_IDX_AUXILIARY_CONTROL_ONE};
		foreach (ix[i]) rc(ix[i], 8'h00);
		for (int i = 2; i < 6; i++) wr(ix[i], 8'h5a + i);
		for (int i = 2; i < 6; i++) rc(ix[i], 8'h5a + i);
		wr(8'h77, 8'hff);
		rc(8'h77, 8'h00);
	endtask
	// Run for a known span; stopped count must hold
	task automatic t_rate();
		t2c_byte_t a;
		wr(`T2C_IDX_CNT_LO, 8'h00);
		wr(`T2C_IDX_CNT_HI, 8'h00);
		wr(`T2C_IDX_CTRL, 8'h04);
		repeat (40) @(posedge clk_i);
		wr(`T2C_IDX_CTRL, 8'h00);
		acc(1'b0, `T2C_IDX_CNT_LO, 8'h00, a);
		rng(a, 20, 22);
		repeat (20) @(posedge clk_i);
		rc(`T2C_IDX_CNT_LO, a);
	endtask
	// Pin source ignores slow clock, slow source ignores the pin
	task automatic t_count();
		t2c_byte_t a;
		wr(`T2C_IDX_CNT_LO, 8'h00);
		wr(`T2C_IDX_CTRL, 8'h06);
		i_t2c_pins_model.pulse(2, 8);
		i_t2c_pins_model.pulse(0, 5);
		wr(`T2C_IDX_CTRL, 8'h00);
		rc(`T2C_IDX_CNT_LO, 8'h05);
		wr(`T2C_IDX_AUXILIARY_CONTROL_ONE, 8'h04);
		wr(`T2C_IDX_CNT_LO, 8'h00);
		wr(`T2C_IDX_CTRL, 8'h06);
		i_t2c_pins_model.pulse(0, 3);
		i_t2c_pins_model.pulse(2, 8);
		wr(`T2C_IDX_CTRL, 8'h00);
		acc(1'b0, `T2C_IDX_CNT_LO, 8'h00, a);
		rng(a, 3, 4);
		wr(`T2C_IDX_AUXILIARY_CONTROL_ONE, 8'h00);
	endtask
	task automatic t_trig();
		wr(`T2C_IDX_CNT_LO, 8'h21);
		wr(`T2C_IDX_CNT_HI, 8'h43);
		wr(`T2C_IDX_CTRL, 8'h01);
		i_t2c_pins_model.pulse(1, 1);
		rc(`T2C_IDX_CTRL, 8'h01);
		rc(`T2C_IDX_RCAP_LO, 8'h5c);
		wr(`T2C_IDX_CTRL, 8'h09);
		i_t2c_pins_model.pulse(1, 1);
		rc(`T2C_IDX_RCAP_LO, 8'h21);
		rc(`T2C_IDX_RCAP_HI, 8'h43);
		repeat (50) @(posedge clk_i);
		rc(`T2C_IDX_CTRL, 8'h49);
		wr(`T2C_IDX_RCAP_LO, 8'hcd);
		wr(`T2C_IDX_CTRL, 8'h08);
		i_t2c_pins_model.pulse(1, 1);
		rc(`T2C_IDX_CNT_LO, 8'hcd);
		rc(`T2C_IDX_CTRL, 8'h48);
	endtask
	// Plain overflow, then baud use on each side with capture mode forced to reload
	task automatic t_ovf();
		int tx0, rx0, tg0, own, oth;
		wr(`T2C_IDX_PIN_FUNC, 8'h02);
		wr(`T2C_IDX_RCAP_LO, 8'hf0);
		wr(`T2C_IDX_RCAP_HI, 8'hff);
		wr(`T2C_IDX_CNT_HI, 8'hff);
		wr(`T2C_IDX_CTRL, 8'h04);
		// Read the flag while still running: any control write would overwrite it
		repeat (110) @(posedge clk_i);
		rc(`T2C_IDX_CTRL, 8'h84);
		wr(`T2C_IDX_CTRL, 8'h00);
		rc(`T2C_IDX_CNT_HI, 8'hff);
		check({7'h00, oe}, 8'h01);
		// Pass 0 gives the transmit side this timer, pass 1 the receive side
		for (int k = 0; k < 2; k++) begin
			tx0 = tx_n;
			rx0 = rx_n;
			tg0 = tog_n;
			wr(`T2C_IDX_CTRL, (k == 0) ? 8'h15 : 8'h25);
			i_t2c_pins_model.pulse(3, 3);
			repeat (100) @(posedge clk_i);
			wr(`T2C_IDX_CTRL, (k == 0) ? 8'h10 : 8'h20);
			repeat (4) @(posedge clk_i);
			own = (k == 0) ? tx_n - tx0 : rx_n - rx0;
			oth = (k == 0) ? rx_n - rx0 : tx_n - tx0;
			rng(own, 3, 5);
			check(8'(tog_n - tg0), 8'(own));
			check(8'(oth), 8'h03);
			rc(`T2C_IDX_CTRL, (k == 0) ? 8'h10 : 8'h20);
			rc(`T2C_IDX_CNT_HI, 8'hff);
		end
		wr(`T2C_IDX_PIN_FUNC, 8'h00);
		repeat (4) @(posedge clk_i);
		check({7'h00, tog}, 8'h00);
	endtask
	// Reset, then the scenarios in turn
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_rate();
		t_count();
		t_trig();
		t_ovf();
		results();
	end
endmodule
